/* hw/link_sync.sv */
// two-flop synchroniser for the link pins
`timescale 1ns/100ps
module link_sync #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q; // first stage, read only by the second
  logic [W-1:0] sync_q; // second stage
  // both stages reset to zero, which means idle and deselected
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end
  assign q = sync_q;
endmodule

/* hw/mem_if.sv */
// port bundle between the target and its byte memory
`timescale 1ns/100ps
interface mem_if #(
  parameter int AW = 12
) ();
  logic [AW-1:0] raddr; // read index
  logic [7:0] rdata; // registered read byte
  logic we; // one-cycle write strobe
  logic [AW-1:0] waddr; // write index
  logic [7:0] wdata; // write byte
  modport owner (output raddr, we, waddr, wdata, input rdata);
  modport store (input raddr, we, waddr, wdata, output rdata);
endinterface

/* hw/mgmt_mem.sv */
// byte memory behind the link, registered read port
`timescale 1ns/100ps
module mgmt_mem #(
  parameter int AW = 12
) (
  input wire logic clk,
  input wire logic rst_b,
  mem_if.store bus
);
  logic [7:0] mem_q [0:(1<<AW)-1]; // contents, no reset
  logic [7:0] rdata_q; // read register
  // write port, one byte per strobe
  always_ff @(posedge clk) begin
    if (bus.we) begin
      mem_q[bus.waddr] <= bus.wdata;
    end
  end
  // read follows the index one cycle later
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= mem_q[bus.raddr];
    end
  end
  assign bus.rdata = rdata_q;
endmodule

/* hw/spi_mgmt_defs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef SPI_MGMT_DEFS_SVH
`define SPI_MGMT_DEFS_SVH
// Behaviour
// RQ1: initiator selects one target at a time
// RQ2: each target gets its own select line
// RQ3: select low starts, high ends and disconnects
// RQ4: each data line carries one direction only
// RQ5: link clock runs from 1 to 20 MHz
// RQ6: initiator starts slow, speeds up after adverts; the host model keeps one fixed rate
// RQ7: low level is zero, high is one
// RQ8: initiator alone makes the link clock
// RQ9: one bit each way every clock
// RQ10: rising edge shifts out and samples
// RQ11: header, flow bytes, then length plus one
// RQ12: read returns data, write data is taken
// RQ13: bits past announced length are ignored
// RQ14: early deselect stops the transaction
// RQ15: first 32 bits form the header
// RQ16: first header bit one means read
// RQ17: header bits 1 to 4 are bank
// RQ18: bits 5 to 15 give length minus one
// RQ19: bank and page come from each header
// RQ20: header bits 16 to 23 are page
// RQ21: bits 24 to 31 start byte, sequential
// RQ22: last flow byte 00h accept, FFh busy
// RQ23: bytes of eight bits, msb first
// RQ24: deselect clears counters and phase
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_HEADER 8'h08
`define REG_COUNT 8'h0c
`define CTRL_BUSY_BIT 0
`define CTRL_FLOW_LSB 4
`define CTRL_FLOW_MSB 7
`define CTRL_FLOW_RESET 4'h2
`define HDR_BYTES 12'h004
`define ACK_BYTE 8'h00
`define NACK_BYTE 8'hff
`define FILL_BYTE 8'h00
`define REF_CLK_HZ 200000000
`define LINK_MAX_HZ 20000000
`define REF_PER_LINK_MIN (`REF_CLK_HZ / `LINK_MAX_HZ)
`endif

/* hw/spi_mgmt_pkg.sv */
// types shared by the management link target
package spi_mgmt_pkg;
  // transaction phase, from the byte position
  typedef enum logic [2:0] {
    PH_HDR = 3'b000,
    PH_FLOW = 3'b001,
    PH_ACK = 3'b010,
    PH_DATA = 3'b011,
    PH_OVER = 3'b100
  } phase_t;
endpackage

/* hw/spi_mgmt_target.sv */
// serial management link target: framing, header decode, register slave
`timescale 1ns/100ps
`include "spi_mgmt_defs.svh"
module spi_mgmt_target #(
  parameter int MEM_AW = 12 // memory index width, 8 to 20
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic target_select_n,
  input wire logic initiator_to_target_data,
  output logic target_to_initiator_data,
  output logic target_to_initiator_data_oe,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  // phase of a byte position; ack index is checked before total,
  // so a stale total cannot matter while the header is open
  function automatic spi_mgmt_pkg::phase_t phase_of(
    input logic [11:0] idx,
    input logic [11:0] ack_idx,
    input logic [11:0] total
  );
    if (idx < `HDR_BYTES) begin
      phase_of = spi_mgmt_pkg::PH_HDR;
    end else if (idx < ack_idx) begin
      phase_of = spi_mgmt_pkg::PH_FLOW;
    end else if (idx == ack_idx) begin
      phase_of = spi_mgmt_pkg::PH_ACK;
    end else if (idx < total) begin
      phase_of = spi_mgmt_pkg::PH_DATA;
    end else begin
      phase_of = spi_mgmt_pkg::PH_OVER;
    end
  endfunction

  // ---- link pins into the ref_clk domain ----
  logic [2:0] pin_s; // synchronised pins
  logic sclk_s; // link clock level
  logic sel_s; // target selected, active high
  logic din_s; // incoming data bit
  // select is inverted first so the reset value means deselected;
  // two ref cycles of sync delay keep up with a 20 MHz link
  link_sync #(
    .W(3)
  ) u_sync (
    .clk(ref_clk),
    .rst_b(rst_b),
    .d({link_clk, ~target_select_n, initiator_to_target_data}),
    .q(pin_s)
  ); // RQ5 RQ7
  assign sclk_s = pin_s[2];
  assign sel_s = pin_s[1];
  assign din_s = pin_s[0];

  logic sclk_prev_q; // last link clock level
  logic sel_prev_q; // last select level
  // edge history for the link clock and select
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_prev_q <= 1'b0;
      sel_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      sel_prev_q <= sel_s;
    end
  end

  logic rise; // link clock rising edge while selected
  assign rise = sel_s & sclk_s & ~sclk_prev_q; // RQ10 RQ3

  // ---- software control ----
  logic ctrl_busy_q; // answer busy in the flow phase
  logic [3:0] ctrl_flow_q; // flow phase length in bytes
  logic [3:0] flow_q; // flow length held for the frame

  // ---- framing state ----
  logic [2:0] bit_q; // bit within the byte
  logic [11:0] byte_q; // completed bytes, saturating
  logic [11:0] byte_nxt; // index of the byte that follows
  logic [11:0] ack_idx; // index of the answer byte
  logic [31:0] hdr_q; // shift of every incoming bit
  logic [31:0] hdr_word; // shift including this bit
  logic [31:0] last_hdr_q; // last complete header
  logic rw_q; // read requested
  logic ack_q; // transaction accepted
  logic [11:0] total_q; // bytes announced in the frame
  logic [7:0] tx_q; // outgoing byte, msb on the pin
  logic oe_q; // drive enable of the outgoing line
  logic byte_done; // last bit of a byte arrives
  logic hdr_done; // last header bit arrives
  logic ack_now; // accept value for this edge
  spi_mgmt_pkg::phase_t cur_ph; // phase of the byte in flight
  spi_mgmt_pkg::phase_t nxt_ph; // phase of the next byte

  // ---- memory side ----
  logic [19:0] addr_q; // bank, page and byte pointer
  logic mem_we_q; // write strobe
  logic [MEM_AW-1:0] waddr_q; // write index
  logic [7:0] wdata_q; // write byte
  mem_if #(
    .AW(MEM_AW)
  ) mem_bus ();

  assign byte_nxt = (byte_q == 12'hfff) ? byte_q : byte_q + 12'h001;
  assign ack_idx = `HDR_BYTES + {8'h00, flow_q} - 12'h001;
  assign cur_ph = phase_of(byte_q, ack_idx, total_q);
  assign nxt_ph = phase_of(byte_nxt, ack_idx, total_q);
  assign byte_done = rise && (bit_q == 3'h7);
  assign hdr_done = byte_done && (byte_q == `HDR_BYTES - 12'h001); // RQ15
  assign hdr_word = {hdr_q[30:0], din_s}; // RQ23
  // the answer byte may be the very next one when the flow length is 1
  assign ack_now = hdr_done ? ~ctrl_busy_q : ack_q;

  // flow length is frozen while selected; zero is taken as one
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      flow_q <= `CTRL_FLOW_RESET;
    end else if (!sel_s) begin
      flow_q <= (ctrl_flow_q == 4'h0) ? 4'h1 : ctrl_flow_q;
    end
  end

  // bit and byte position, restarted by every deselect
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_q <= 3'h0;
      byte_q <= 12'h000;
    end else if (!sel_s) begin
      bit_q <= 3'h0; // RQ24 RQ14
      byte_q <= 12'h000; // RQ24
    end else if (rise) begin
      bit_q <= bit_q + 3'h1; // RQ9
      if (bit_q == 3'h7) begin
        byte_q <= byte_nxt; // RQ23
      end
    end
  end

  // incoming bits shift in msb first on each rising link edge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hdr_q <= 32'h0000_0000;
    end else if (rise) begin
      hdr_q <= hdr_word; // RQ10 RQ4
    end
  end

  // header decode once all 32 bits are in
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      last_hdr_q <= 32'h0000_0000;
      rw_q <= 1'b0;
      ack_q <= 1'b0;
      total_q <= 12'hfff;
    end else if (hdr_done) begin
      last_hdr_q <= hdr_word; // RQ15
      rw_q <= hdr_word[31]; // RQ16
      ack_q <= ~ctrl_busy_q; // RQ22
      // header, flow bytes, then length field plus one data bytes
      total_q <= ack_idx + 12'h002 + {1'b0, hdr_word[26:16]}; // RQ11 RQ18
    end
  end

  // outgoing byte: loaded at byte boundaries, shifted on rising edges
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_q <= `FILL_BYTE;
    end else if (!sel_s) begin
      tx_q <= `FILL_BYTE; // RQ24
    end else if (byte_done) begin
      case (nxt_ph)
        // accept or busy in the last flow byte
        spi_mgmt_pkg::PH_ACK: begin
          tx_q <= ack_now ? `ACK_BYTE : `NACK_BYTE; // RQ22
        end
        // read data only for an accepted read
        spi_mgmt_pkg::PH_DATA: begin
          tx_q <= (rw_q && ack_q) ? mem_bus.rdata : `FILL_BYTE; // RQ12
        end
        // header, filler flow bytes and overrun send zeros
        default: begin
          tx_q <= `FILL_BYTE; // RQ13
        end
      endcase
    end else if (rise) begin
      tx_q <= {tx_q[6:0], 1'b0}; // RQ10 RQ23
    end
  end

  // line driven only while selected, released on deselect
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= sel_s; // RQ3 RQ4
    end
  end

  assign target_to_initiator_data = tx_q[7];
  assign target_to_initiator_data_oe = oe_q;

  // address pointer and writes; a partial byte never reaches memory
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_q <= 20'h00000;
      mem_we_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= 8'h00;
    end else begin
      mem_we_q <= 1'b0;
      if (hdr_done) begin
        // full bank, page and byte address from every header
        addr_q <= {hdr_word[30:27], hdr_word[15:0]}; // RQ17 RQ19 RQ20 RQ21
      end else if (byte_done && nxt_ph == spi_mgmt_pkg::PH_DATA && rw_q) begin
        // fetch ahead: the byte just loaded frees the pointer
        addr_q <= addr_q + 20'h00001; // RQ21
      end else if (byte_done && cur_ph == spi_mgmt_pkg::PH_DATA && !rw_q && ack_q) begin
        mem_we_q <= 1'b1; // RQ12 RQ14
        waddr_q <= addr_q[MEM_AW-1:0];
        wdata_q <= hdr_word[7:0];
        addr_q <= addr_q + 20'h00001; // RQ21
      end
    end
  end

  assign mem_bus.raddr = addr_q[MEM_AW-1:0];
  assign mem_bus.we = mem_we_q;
  assign mem_bus.waddr = waddr_q;
  assign mem_bus.wdata = wdata_q;

  // bank and page bits above MEM_AW are dropped by the small memory
  mgmt_mem #(
    .AW(MEM_AW)
  ) u_mem (
    .clk(ref_clk),
    .rst_b(rst_b),
    .bus(mem_bus.store)
  );

  // ---- transaction counters ----
  logic [15:0] done_cnt_q; // frames ended at or past length
  logic [15:0] abort_cnt_q; // frames cut short
  // a frame is complete when it ends on a byte boundary at or past
  // its length; total is never below six, so a short header aborts
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      done_cnt_q <= 16'h0000;
      abort_cnt_q <= 16'h0000;
    end else if (sel_prev_q && !sel_s) begin
      if (bit_q == 3'h0 && byte_q >= total_q) begin
        done_cnt_q <= done_cnt_q + 16'h0001;
      end else begin
        abort_cnt_q <= abort_cnt_q + 16'h0001; // RQ14
      end
    end
  end

  // ---- ahb-lite slave, zero wait states ----
  logic ahb_take; // address phase accepted
  logic ahb_wr_q; // write data phase pending
  logic [7:0] ahb_addr_q; // latched write offset
  logic [31:0] hrdata_q; // read data register
  logic hreadyout_q; // always ready
  logic hresp_q; // always okay
  logic [31:0] reg_rd; // read mux
  logic ahb_hit; // address within the register page

  assign ahb_take = hsel && hready && htrans[1];
  assign ahb_hit = (haddr[31:8] == 24'h000000);

  // register read mux; unmapped offsets read zero
  always_comb begin
    reg_rd = 32'h0000_0000;
    if (ahb_hit) begin
      case (haddr[7:0])
        `REG_CTRL: begin
          reg_rd[`CTRL_BUSY_BIT] = ctrl_busy_q;
          reg_rd[`CTRL_FLOW_MSB:`CTRL_FLOW_LSB] = ctrl_flow_q;
        end
        `REG_STATUS: begin
          reg_rd[5:0] = {ack_q, rw_q, cur_ph, sel_s};
        end
        `REG_HEADER: begin
          reg_rd = last_hdr_q;
        end
        `REG_COUNT: begin
          reg_rd = {abort_cnt_q, done_cnt_q};
        end
        default: begin
          reg_rd = 32'h0000_0000;
        end
      endcase
    end
  end

  // address phase capture; read data ready in the data phase
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ahb_wr_q <= 1'b0;
      ahb_addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      ahb_wr_q <= ahb_take && hwrite && ahb_hit;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      if (ahb_take) begin
        ahb_addr_q <= haddr[7:0];
      end
      if (ahb_take && !hwrite) begin
        hrdata_q <= reg_rd;
      end
    end
  end

  // control write in the data phase; flow length takes effect at next select, busy at the next header end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_busy_q <= 1'b0;
      ctrl_flow_q <= `CTRL_FLOW_RESET;
    end else if (ahb_wr_q && ahb_addr_q == `REG_CTRL) begin
      ctrl_busy_q <= hwdata[`CTRL_BUSY_BIT];
      ctrl_flow_q <= hwdata[`CTRL_FLOW_MSB:`CTRL_FLOW_LSB];
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;

  // ---- checks ----
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_hdr_done;
    byte_done && byte_q == `HDR_BYTES - 12'h001;
  endsequence

  a_dsel_clear: assert property (!sel_s |=> bit_q == 3'h0 && byte_q == 12'h000) // RQ24
    else $error("counters not cleared on deselect");
  a_release_out: assert property (!sel_s |=> !target_to_initiator_data_oe) // RQ3
    else $error("output driven while deselected");
  a_ack_byte: assert property (byte_done && nxt_ph == spi_mgmt_pkg::PH_ACK |=> // RQ22
    tx_q == `ACK_BYTE || tx_q == `NACK_BYTE)
    else $error("flow answer not all zeros or all ones");
  a_hdr_dir: assert property (s_hdr_done |=> rw_q == $past(hdr_q[30])) // RQ16
    else $error("direction not taken from first bit");
  a_len_total: assert property (s_hdr_done |=> // RQ11 RQ18
    total_q == `HDR_BYTES + {8'h00, flow_q} + {1'b0, last_hdr_q[26:16]} + 12'h001)
    else $error("frame length wrong");
  a_base_addr: assert property (s_hdr_done |=> // RQ17 RQ19 RQ20 RQ21
    addr_q == {last_hdr_q[30:27], last_hdr_q[15:0]})
    else $error("start address not from header");
  a_over_quiet: assert property (byte_done && cur_ph == spi_mgmt_pkg::PH_OVER |=> // RQ13
    !mem_we_q && tx_q == `FILL_BYTE)
    else $error("overrun bits acted upon");
  a_out_on_edge: assert property (sel_s && $past(sel_s) && $changed(tx_q) |-> $past(rise)) // RQ10
    else $error("output moved without a link edge");
  a_write_whole: assert property (mem_we_q |-> $past(rise) && $past(bit_q) == 3'h7 && !rw_q) // RQ12 RQ14
    else $error("write without a whole byte");

endmodule

/* testbench/spi_host_model.sv */
// initiator model: makes the link clock, the select and the outbound data
`timescale 1ns/100ps
module spi_host_model (
  output logic link_clk,
  output logic target_select_n,
  output logic initiator_to_target_data,
  input wire logic target_to_initiator_data
);
  // idle link: clock parked low, target deselected
  initial begin
    link_clk = 1'b0;
    target_select_n = 1'b1;
    initiator_to_target_data = 1'b0;
  end
  // one frame of nbits edges; rx collects every whole byte seen
  task automatic frame(input logic [7:0] tx[$], input int nbits, output logic [7:0] rx[$]);
    logic [7:0] sh;
    int i;
    rx = {};
    sh = 8'h00;
    initiator_to_target_data = tx[0][7];
    #50 target_select_n = 1'b0;
    #200;
    for (i = 0; i < nbits; i++) begin
      link_clk = 1'b1;
      sh = {sh[6:0], target_to_initiator_data};
      if (i % 8 == 7) begin
        rx.push_back(sh);
      end
      // next bit goes out after a hold long enough for the target's pin synchroniser,
      // which samples a few ref cycles after the edge; zeros past the queue
      #20 initiator_to_target_data = ((i + 1) / 8 < tx.size()) ? tx[(i + 1) / 8][7 - (i + 1) % 8] : 1'b0;
      // one fixed rate for the whole run, so the speed never changes before adverts are read
      #42.5 link_clk = 1'b0;
      #62.5;
    end
    #100 target_select_n = 1'b1;
    // line released: show the inverse, never a stale bit
    initiator_to_target_data = ~initiator_to_target_data;
    #500;
  endtask
endmodule

/* testbench/test_spi_mgmt_transaction_framing.sv */
// self-checking bench for the management link target
`timescale 1ns/100ps
module test_spi_mgmt_transaction_framing;
  logic ref_clk, rst_b, link_clk, sel_n, ito, tio, tio_oe, hsel, hwrite, hresp;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire hreadyout;
  wire tio_pin;
  int fails, check_count, done_n, abort_n, k, n;
  logic [7:0] pg, by, ack;
  logic [3:0] bk;
  logic [7:0] q[$];
  logic [7:0] mirror [logic [11:0]]; // expected memory contents
  logic [31:0] regs [5] = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h10};
  logic [31:0] rexp [5] = '{32'h20, 32'h0, 32'h0, 32'h0, 32'h0};
  // a released target output floats
  assign tio_pin = tio_oe ? tio : 1'bz;
  spi_mgmt_target #(.MEM_AW(12)) u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .link_clk(link_clk),
    .target_select_n(sel_n), .initiator_to_target_data(ito), .target_to_initiator_data(tio),
    .target_to_initiator_data_oe(tio_oe), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  spi_host_model u_host (.link_clk(link_clk), .target_select_n(sel_n), .initiator_to_target_data(ito),
    .target_to_initiator_data(tio_pin));
  // 200 MHz system clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_of_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // one single-word bus transfer, waits on hready in both phases
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // frame = header, nflow filler bytes, payload; extra trims or stretches the bit count
  task automatic xfer(input logic [31:0] hdr, input int nflow, input logic [7:0] pay[$], input int extra,
                      output logic [7:0] ak, output logic [7:0] rq[$]);
    logic [7:0] tx[$];
    logic [7:0] rx[$];
    int i;
    tx = {hdr[31:24], hdr[23:16], hdr[15:8], hdr[7:0]};
    for (i = 0; i < nflow; i++) begin
      tx.push_back(8'h00);
    end
    tx = {tx, pay};
    u_host.frame(tx, (4 + nflow + pay.size()) * 8 + extra, rx);
    ak = (rx.size() > 3 + nflow) ? rx[3 + nflow] : 8'hxx;
    rq = {};
    for (i = 4 + nflow; i < rx.size(); i++) begin
      rq.push_back(rx[i]);
    end
  endtask
  // write n random bytes, plus surplus bytes past the announced length
  task automatic wr_frame(input int nb, input int surplus, input int nflow, input logic [7:0] exp_ack);
    logic [7:0] pay[$];
    logic [7:0] rq[$];
    logic [7:0] ak;
    int i;
    for (i = 0; i < nb + surplus; i++) begin
      pay.push_back(8'($urandom));
    end
    xfer({1'b0, bk, 11'(nb - 1), pg, by}, nflow, pay, 0, ak, rq);
    chk(32'(ak), 32'(exp_ack));
    for (i = 0; i < nb && exp_ack == 8'h00; i++) begin
      mirror[{pg[3:0], by} + 12'(i)] = pay[i];
    end
    done_n++;
  endtask
  // read n bytes and compare with what was written
  task automatic rd_chk(input int nb, input int nflow, input logic [7:0] exp_ack);
    logic [7:0] z[$];
    logic [7:0] rq[$];
    logic [7:0] ak;
    logic [31:0] hdr;
    int i;
    for (i = 0; i < nb; i++) begin
      z.push_back(8'h00);
    end
    hdr = {1'b1, bk, 11'(nb - 1), pg, by};
    xfer(hdr, nflow, z, 0, ak, rq);
    chk(32'(ak), 32'(exp_ack));
    for (i = 0; i < nb; i++) begin
      chk(32'(rq[i]), exp_ack == 8'h00 ? 32'(mirror[{pg[3:0], by} + 12'(i)]) : 32'h0);
    end
    ahb(1'b0, 32'h8, 32'h0, r);
    chk(r, hdr);
    // line must be released once deselected
    chk(32'(tio_oe), 32'h0);
    done_n++;
  endtask
  // hang guard, well past the expected run
  initial begin
    #400000;
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test();
  end
  initial begin
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    fails = 0;
    check_count = 0;
    done_n = 0;
    abort_n = 0;
    void'($urandom(32'h95e2));
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    // reset values, unmapped write ignored
    ahb(1'b1, 32'h10, 32'hffff_ffff, r);
    foreach (regs[i]) begin
      ahb(1'b0, regs[i], 32'h0, r);
      chk(r, rexp[i]);
    end
    $display("test regs done");
    // write then read back, flow field swept 0..4, zero acts as one
    for (k = 0; k <= 4; k++) begin
      ahb(1'b1, 32'h0, 32'(k << 4), r);
      bk = 4'($urandom);
      pg = 8'($urandom);
      by = 8'($urandom);
      n = $urandom_range(6, 2);
      wr_frame(n, 0, (k == 0) ? 1 : k, 8'h00);
      rd_chk(n, (k == 0) ? 1 : k, 8'h00);
      ahb(1'b0, 32'h4, 32'h0, r);
      chk(r, 32'h30);
    end
    $display("test stream done");
    // busy: all-ones answer, write dropped, read gives filler
    ahb(1'b1, 32'h0, 32'h21, r);
    wr_frame(1, 0, 2, 8'hff);
    rd_chk(1, 2, 8'hff);
    ahb(1'b0, 32'h4, 32'h0, r);
    chk(r, 32'h10);
    ahb(1'b1, 32'h0, 32'h20, r);
    rd_chk(n, 2, 8'h00);
    $display("test busy done");
    // one byte announced, two sent: the second must not land
    wr_frame(1, 1, 2, 8'h00);
    rd_chk(n, 2, 8'h00);
    $display("test overrun done");
    // cut short: mid-header, long read, write mid-byte
    xfer({1'b1, bk, 11'd0, pg, by}, 2, q, -36, ack, q);
    xfer({1'b1, bk, 11'd256, pg, by}, 2, '{8'h00, 8'h00}, 0, ack, q);
    xfer({1'b0, bk, 11'd1, pg + 8'h01, by}, 2, '{8'h5a, 8'ha5}, -5, ack, q);
    abort_n += 3;
    rd_chk(n, 2, 8'h00);
    ahb(1'b0, 32'hc, 32'h0, r);
    chk(r, {abort_n[15:0], done_n[15:0]});
    $display("test abort done");
    end_of_test();
  end
endmodule
